// ==== shared/phy_select_defines.svh ====
`ifndef PHY_SELECT_DEFINES_SVH
`define PHY_SELECT_DEFINES_SVH

// ****************************************************************
// Reset values and timing counts.
// ****************************************************************

// Synchroniser flops reset to the pulled-down (low) pin level.
`define SYNC_RESET_VALUE 6'h00
// Both PHY enables are off out of reset.
`define PHY_EN_RESET 2'h0
// Edges after reset release before the second sync stage holds a real pin sample.
`define PRIME_CYCLES 2'h2
// Reset value of the priming counter.
`define PRIME_RESET 2'h0

`endif

// ==== shared/phy_select_pkg.sv ====
// ****************************************************************
// Types shared by the PHY select logic.
// ****************************************************************
package phy_select_pkg;

	// Raw or synchronised connector-detector pins, in one bundle.
	typedef struct packed {
		logic scheme_select;
		logic polarity_strap;
		logic attach_detect;
		logic orientation_select;
		logic attach_orient_a;
		logic attach_orient_b;
	} pin_bundle_t;

	// The two orientation PHY enables.
	typedef struct packed {
		logic phy_a;
		logic phy_b;
	} phy_enable_t;

	// Control scheme, as chosen by the scheme select pin.
	typedef enum logic {
		SCHEME_ONE = 1'b0,
		SCHEME_TWO = 1'b1
	} scheme_t;

endpackage : phy_select_pkg

// ==== src/pin_sync.sv ====
`timescale 1ns/10ps
`default_nettype none
`include "phy_select_defines.svh"

// ****************************************************************
// Two-flop synchroniser for the whole pin bundle.
// ****************************************************************
module pin_sync (
	input  wire logic                        clk_in,
	input  wire logic                        nrst_in,
	input  wire phy_select_pkg::pin_bundle_t pins_in,
	output var  phy_select_pkg::pin_bundle_t pins_out
);

	phy_select_pkg::pin_bundle_t meta_q;

	// The first stage is read only by the second; nothing else looks at it.
	always_ff @(posedge clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			meta_q   <= `SYNC_RESET_VALUE;
			pins_out <= `SYNC_RESET_VALUE;
		end else begin
			meta_q   <= pins_in;
			pins_out <= meta_q;
		end
	end

endmodule : pin_sync
`default_nettype wire

// ==== src/phy_select.sv ====
`timescale 1ns/10ps
`default_nettype none
`include "phy_select_defines.svh"

module phy_select (
	input  wire logic CLOCK_IN,
	input  wire logic NRST_IN,
	input  wire logic CONTROL_SCHEME_SELECT_IN,
	input  wire logic ATTACH_POLARITY_STRAP_IN,
	input  wire logic ATTACH_DETECT_IN,
	input  wire logic ORIENTATION_SELECT_IN,
	input  wire logic ATTACH_ORIENT_A_IN,
	input  wire logic ATTACH_ORIENT_B_IN,
	output logic      PHY_A_ENABLE_OUT,
	output logic      PHY_B_ENABLE_OUT
);

	// ****************************************************************
	// Decode.
	// ****************************************************************

	// Maps one synchronised sample onto the PHY enables.
	// The strap is applied here, after the flops, so a strap change and the pin
	// changes that go with it are undone by one and the same sampled value.
	// Both PHYs on would put two lanes onto one host link, so any doubt
	// resolves to both off; the port then stays dark rather than half alive.
	function automatic phy_select_pkg::phy_enable_t decode(
		input phy_select_pkg::pin_bundle_t p
	);
		phy_select_pkg::phy_enable_t r;
		logic                        attach;
		logic                        orient;
		logic                        att_a;
		logic                        att_b;
		// A high strap turns every attach and orientation pin active low.
		attach = p.attach_detect ^ p.polarity_strap;
		orient = p.orientation_select ^ p.polarity_strap;
		att_a  = p.attach_orient_a ^ p.polarity_strap;
		att_b  = p.attach_orient_b ^ p.polarity_strap;
		r      = `PHY_EN_RESET;
		if (phy_select_pkg::scheme_t'(p.scheme_select) == phy_select_pkg::SCHEME_TWO) begin
			// Both asserted is ambiguous, so neither PHY is risked.
			r.phy_a = att_a & ~att_b;
			r.phy_b = att_b & ~att_a;
		end else begin
			// Orientation only matters once an attach is present.
			r.phy_a = attach & ~orient;
			r.phy_b = attach & orient;
		end
		return r;
	endfunction : decode

	// ****************************************************************
	// Input synchronisation.
	// ****************************************************************

	phy_select_pkg::pin_bundle_t raw_pins;
	phy_select_pkg::pin_bundle_t sync_pins;
	phy_select_pkg::phy_enable_t phy_en_q;
	phy_select_pkg::phy_enable_t phy_en_d;
	logic [1:0]                  prime_q;
	logic                        primed;

	// Gather the pins; unconnected straps read low through the pad pull-downs.
	assign raw_pins.scheme_select      = CONTROL_SCHEME_SELECT_IN;
	assign raw_pins.polarity_strap     = ATTACH_POLARITY_STRAP_IN;
	assign raw_pins.attach_detect      = ATTACH_DETECT_IN;
	assign raw_pins.orientation_select = ORIENTATION_SELECT_IN;
	assign raw_pins.attach_orient_a    = ATTACH_ORIENT_A_IN;
	assign raw_pins.attach_orient_b    = ATTACH_ORIENT_B_IN;

	// Every pin is asynchronous to the core clock.
	// Each bit resolves on its own, so a strap flip and a pin flip in one cycle
	// may land one edge apart and give a single wrong enable cycle. Straps are
	// expected to settle at power-up, so no debounce stage is spent on this.
	pin_sync u_pin_sync (
		.clk_in  (CLOCK_IN),
		.nrst_in (NRST_IN),
		.pins_in (raw_pins),
		.pins_out(sync_pins)
	);

	// ****************************************************************
	// Priming after reset.
	// ****************************************************************

	// The second stage holds the reset value until two edges have passed,
	// so decoding waits for it rather than acting on a stale low.
	// All-zero flops happen to decode to both off, but the counter keeps that
	// true without leaning on the reset values of the synchroniser.
	always_ff @(posedge CLOCK_IN or negedge NRST_IN) begin
		if (!NRST_IN) begin
			prime_q <= `PRIME_RESET;
		end else if (prime_q != `PRIME_CYCLES) begin
			prime_q <= prime_q + 2'h1;
		end
	end

	// The counter parks at its end value, so primed stays high until the next reset.
	assign primed = (prime_q == `PRIME_CYCLES);

	// ****************************************************************
	// PHY enable register.
	// ****************************************************************

	// Next value: off until primed, then the decoded sample.
	always_comb begin
		phy_en_d = `PHY_EN_RESET;
		if (primed) begin
			phy_en_d = decode(sync_pins);
		end
	end

	// Enables come straight from flops so the PHYs never see a glitch.
	// The cost is one more edge of latency, three in all from pin to enable.
	always_ff @(posedge CLOCK_IN or negedge NRST_IN) begin
		if (!NRST_IN) begin
			phy_en_q <= `PHY_EN_RESET;
		end else begin
			phy_en_q <= phy_en_d;
		end
	end

	// Outputs are plain wires from the enable register.
	assign PHY_A_ENABLE_OUT = phy_en_q.phy_a;
	assign PHY_B_ENABLE_OUT = phy_en_q.phy_b;

	// ****************************************************************
	// Assertions.
	// ****************************************************************

	// Antecedents read the synchronised pins at one edge; the enable register
	// answers at the next, so consequents use |=> and $past of the pins.
	// Enables only follow the pins once primed, hence the guard in most checks.

	// Strap low: orientation high picks B, orientation low picks A.
	chk_s1_strap_low: assert property (
		@(posedge CLOCK_IN) disable iff (!NRST_IN)
		primed && !sync_pins.scheme_select && !sync_pins.polarity_strap
			&& sync_pins.attach_detect
		|=> (phy_en_q.phy_b == $past(sync_pins.orientation_select))
			&& (phy_en_q.phy_a == !$past(sync_pins.orientation_select))
	) else $error("Scheme 1 with strap low picked the wrong PHY.");

	// Strap high: the attach pin is low when asserted and orientation high picks A.
	chk_s1_strap_high: assert property (
		@(posedge CLOCK_IN) disable iff (!NRST_IN)
		primed && !sync_pins.scheme_select && sync_pins.polarity_strap
			&& !sync_pins.attach_detect
		|=> (phy_en_q.phy_a == $past(sync_pins.orientation_select))
			&& (phy_en_q.phy_b == !$past(sync_pins.orientation_select))
	) else $error("Scheme 1 with strap high picked the wrong PHY.");

	// Flipping the connector over with the attach held swaps the two enables.
	chk_s1_flip_swap: assert property (
		@(posedge CLOCK_IN) disable iff (!NRST_IN)
		primed && $past(primed) && !sync_pins.scheme_select
			&& !$past(sync_pins.scheme_select)
			&& (sync_pins.attach_detect != sync_pins.polarity_strap)
			&& $stable(sync_pins.attach_detect) && $stable(sync_pins.polarity_strap)
			&& $changed(sync_pins.orientation_select)
		|=> (phy_en_q.phy_a == $past(phy_en_q.phy_b))
			&& (phy_en_q.phy_b == $past(phy_en_q.phy_a))
	) else $error("Flipping the orientation did not swap the PHYs.");

	// In scheme 1, an attach pin at its deasserted level leaves both PHYs off.
	chk_s1_no_attach: assert property (
		@(posedge CLOCK_IN) disable iff (!NRST_IN)
		!sync_pins.scheme_select
			&& (sync_pins.attach_detect == sync_pins.polarity_strap)
		|=> !phy_en_q.phy_a && !phy_en_q.phy_b
	) else $error("A PHY is on in scheme 1 without an attach.");

	// A low scheme select with an attach present must pick exactly one PHY.
	chk_s1_one_phy: assert property (
		@(posedge CLOCK_IN) disable iff (!NRST_IN)
		primed && !sync_pins.scheme_select
			&& (sync_pins.attach_detect != sync_pins.polarity_strap)
		|=> phy_en_q.phy_a != phy_en_q.phy_b
	) else $error("Scheme 1 with an attach did not pick exactly one PHY.");

	// Scheme 1 enables must not move when only the A and B pins move.
	chk_s1_ignores_ab: assert property (
		@(posedge CLOCK_IN) disable iff (!NRST_IN)
		primed && !sync_pins.scheme_select && $stable(sync_pins.attach_detect)
			&& $stable(sync_pins.orientation_select)
			&& $stable(sync_pins.polarity_strap) && !$past(sync_pins.scheme_select)
			&& $past(primed)
		|=> $stable(phy_en_q)
	) else $error("Scheme 1 enables moved with a scheme 2 pin.");

	// Scheme 2 enables must not move when only the scheme 1 pins move.
	chk_s2_ignores_s1: assert property (
		@(posedge CLOCK_IN) disable iff (!NRST_IN)
		primed && sync_pins.scheme_select && $stable(sync_pins.attach_orient_a)
			&& $stable(sync_pins.attach_orient_b)
			&& $stable(sync_pins.polarity_strap) && $past(sync_pins.scheme_select)
			&& $past(primed)
		|=> $stable(phy_en_q)
	) else $error("Scheme 2 enables moved with a scheme 1 pin.");

	// Active-high scheme 2: the A pin alone selects PHY A.
	chk_s2_a_on: assert property (
		@(posedge CLOCK_IN) disable iff (!NRST_IN)
		primed && sync_pins.scheme_select && !sync_pins.polarity_strap
			&& sync_pins.attach_orient_a && !sync_pins.attach_orient_b
		|=> phy_en_q.phy_a && !phy_en_q.phy_b
	) else $error("Scheme 2 did not switch on PHY A.");

	// Active-high scheme 2: the B pin alone selects PHY B.
	chk_s2_b_on: assert property (
		@(posedge CLOCK_IN) disable iff (!NRST_IN)
		primed && sync_pins.scheme_select && !sync_pins.polarity_strap
			&& !sync_pins.attach_orient_a && sync_pins.attach_orient_b
		|=> phy_en_q.phy_b && !phy_en_q.phy_a
	) else $error("Scheme 2 did not switch on PHY B.");

	// Active-low scheme 2: a low B pin alone selects PHY B.
	chk_low_active_b: assert property (
		@(posedge CLOCK_IN) disable iff (!NRST_IN)
		primed && sync_pins.scheme_select && sync_pins.polarity_strap
			&& sync_pins.attach_orient_a && !sync_pins.attach_orient_b
		|=> phy_en_q.phy_b && !phy_en_q.phy_a
	) else $error("Active-low scheme 2 did not switch on PHY B.");

	// Active-low scheme 2: a low A pin alone selects PHY A.
	chk_low_active_a: assert property (
		@(posedge CLOCK_IN) disable iff (!NRST_IN)
		primed && sync_pins.scheme_select && sync_pins.polarity_strap
			&& !sync_pins.attach_orient_a && sync_pins.attach_orient_b
		|=> phy_en_q.phy_a && !phy_en_q.phy_b
	) else $error("Active-low scheme 2 did not switch on PHY A.");

	// A deasserted A pin keeps PHY A dark, whatever the B pin does.
	chk_s2_off_deassert: assert property (
		@(posedge CLOCK_IN) disable iff (!NRST_IN)
		sync_pins.scheme_select
			&& (sync_pins.attach_orient_a == sync_pins.polarity_strap)
		|=> !phy_en_q.phy_a
	) else $error("PHY A is on with its attach pin deasserted.");

	// A deasserted B pin keeps PHY B dark, whatever the A pin does.
	chk_s2_b_off: assert property (
		@(posedge CLOCK_IN) disable iff (!NRST_IN)
		sync_pins.scheme_select
			&& (sync_pins.attach_orient_b == sync_pins.polarity_strap)
		|=> !phy_en_q.phy_b
	) else $error("PHY B is on with its attach pin deasserted.");

	// Equal A and B pins mean both attached or neither, and either way no PHY runs.
	chk_s2_pair_off: assert property (
		@(posedge CLOCK_IN) disable iff (!NRST_IN)
		sync_pins.scheme_select
			&& (sync_pins.attach_orient_a == sync_pins.attach_orient_b)
		|=> !phy_en_q.phy_a && !phy_en_q.phy_b
	) else $error("Scheme 2 enabled a PHY with both attach pins equal.");

	// Active-high pins held steady reach the enables three edges after sampling.
	chk_pin_latency: assert property (
		@(posedge CLOCK_IN) disable iff (!NRST_IN)
		primed && !ATTACH_POLARITY_STRAP_IN && !CONTROL_SCHEME_SELECT_IN
			&& ATTACH_DETECT_IN && !ORIENTATION_SELECT_IN
		##1 $stable(raw_pins) ##1 $stable(raw_pins)
		|=> phy_en_q.phy_a && !phy_en_q.phy_b
	) else $error("Active-high pins did not reach PHY A in three edges.");

	// Two lanes on one link is never acceptable, primed or not.
	chk_never_both: assert property (
		@(posedge CLOCK_IN) disable iff (!NRST_IN)
		!(phy_en_q.phy_a && phy_en_q.phy_b)
	) else $error("Both PHYs are enabled at once.");

	// Nothing is switched on while the synchroniser still holds reset values.
	chk_prime_hold: assert property (
		@(posedge CLOCK_IN) disable iff (!NRST_IN)
		!primed |=> !phy_en_q.phy_a && !phy_en_q.phy_b
	) else $error("A PHY came on before the inputs were sampled.");

	// Before priming the straps read their unconnected, low level.
	chk_strap_default: assert property (
		@(posedge CLOCK_IN) disable iff (!NRST_IN)
		!primed |-> !sync_pins.polarity_strap && !sync_pins.scheme_select
	) else $error("Straps left the reset default before priming.");

	// Priming lasts exactly two edges from the counter's reset value.
	chk_prime_bound: assert property (
		@(posedge CLOCK_IN) disable iff (!NRST_IN)
		prime_q == `PRIME_RESET |-> ##2 primed
	) else $error("Priming took other than two edges.");

	// The first edge after release must find the counter and enables at rest.
	chk_release_clean: assert property (
		@(posedge CLOCK_IN) disable iff (!NRST_IN)
		$rose(NRST_IN)
		|-> (prime_q == `PRIME_RESET) && !phy_en_q.phy_a && !phy_en_q.phy_b
	) else $error("Reset release did not start from a clean state.");

endmodule : phy_select
`default_nettype wire

// ==== dv/detector_model.sv ====
`timescale 1ns/10ps
`default_nettype none

// ****************************************************************
// Behavioural connector detector on the far side of the pins.
// ****************************************************************
module detector_model (
	input  wire phy_select_pkg::pin_bundle_t want_in,
	output var  phy_select_pkg::pin_bundle_t pins_out
);
	// The wanted state is logical; an active-low board flips every signal pin.
	// Strap and scheme pass straight, so the board alone picks the scheme.
	always_comb begin
		pins_out = want_in ^ {2'h0, {4{want_in.polarity_strap}}};
	end
endmodule : detector_model

`default_nettype wire

// ==== dv/phy_select_tb_top.sv ====
`timescale 1ns/10ps
`default_nettype none

// ****************************************************************
// Self-checking bench for the PHY select logic.
// ****************************************************************
module phy_select_tb_top;
	logic                        clk     = 1'b0;
	logic                        nrst    = 1'b0;
	phy_select_pkg::pin_bundle_t want    = 6'h00;
	phy_select_pkg::pin_bundle_t pins;
	logic                        phy_a;
	logic                        phy_b;
	phy_select_pkg::phy_enable_t got;
	int                          fails   = 0;
	int                          n_tests = 0;

	// Free-running core clock, 40 ns period.
	initial begin
		forever #20 clk = ~clk;
	end

	detector_model model (.want_in(want), .pins_out(pins));

	phy_select dut (
		.CLOCK_IN                 (clk),
		.NRST_IN                  (nrst),
		.CONTROL_SCHEME_SELECT_IN (pins.scheme_select),
		.ATTACH_POLARITY_STRAP_IN (pins.polarity_strap),
		.ATTACH_DETECT_IN         (pins.attach_detect),
		.ORIENTATION_SELECT_IN    (pins.orientation_select),
		.ATTACH_ORIENT_A_IN       (pins.attach_orient_a),
		.ATTACH_ORIENT_B_IN       (pins.attach_orient_b),
		.PHY_A_ENABLE_OUT         (phy_a),
		.PHY_B_ENABLE_OUT         (phy_b)
	);
	assign got = {phy_a, phy_b};

	// Expected enables from the logical pin state; never both on.
	function automatic phy_select_pkg::phy_enable_t decode(input phy_select_pkg::pin_bundle_t w);
		if (w.scheme_select) begin
			return {w.attach_orient_a & ~w.attach_orient_b, w.attach_orient_b & ~w.attach_orient_a};
		end
		return {w.attach_detect & ~w.orientation_select, w.attach_detect & w.orientation_select};
	endfunction : decode

	task automatic check_phy(input phy_select_pkg::phy_enable_t exp);
		n_tests++;
		if (got !== exp) begin
			fails++;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : check_phy

	// Four edges cover the three-edge latency plus one for metastability.
	task automatic apply(input phy_select_pkg::pin_bundle_t w);
		@(posedge clk);
		want <= w;
		repeat (4) @(posedge clk);
		@(negedge clk);
	endtask : apply

	// Reset with pins set, then watch the two priming edges and the first decode.
	task automatic do_reset(input phy_select_pkg::pin_bundle_t w);
		@(posedge clk);
		nrst <= 1'b0;
		want <= w;
		@(negedge clk);
		check_phy(2'h0);
		repeat (5) @(posedge clk);
		nrst <= 1'b1;
		@(negedge clk);
		check_phy(2'h0);
		repeat (2) begin
			@(posedge clk);
			@(negedge clk);
			check_phy(2'h0);
		end
		@(posedge clk);
		@(negedge clk);
		check_phy(decode(w));
	endtask : do_reset

	// Scheme 1, every strap, attach and orientation; A and B pins carry noise.
	task automatic t_scheme_one;
		phy_select_pkg::pin_bundle_t w;
		for (int i = 0; i < 8; i++) begin
			w = {1'b0, i[2:0], 2'h2};
			apply(w);
			check_phy(decode(w));
			// Swap the scheme 2 pins alone; scheme 1 must not notice.
			w.attach_orient_a = 1'b0;
			w.attach_orient_b = 1'b1;
			apply(w);
			check_phy(decode(w));
		end
		$display("t_scheme_one done");
	endtask : t_scheme_one

	// Scheme 2, every strap, A and B; attach and orientation carry noise.
	task automatic t_scheme_two;
		phy_select_pkg::pin_bundle_t w;
		for (int i = 0; i < 8; i++) begin
			w = {1'b1, i[2], 1'b1, i[1], i[1], i[0]};
			apply(w);
			check_phy(decode(w));
			// Move the scheme 1 pins alone; scheme 2 must not notice.
			w.attach_detect      = ~w.attach_detect;
			w.orientation_select = ~w.orientation_select;
			apply(w);
			check_phy(decode(w));
		end
		$display("t_scheme_two done");
	endtask : t_scheme_two

	// Strap and scheme left low, as if unconnected: active-high scheme 1.
	task automatic t_defaults;
		apply(6'h08);
		check_phy(2'h2);
		apply(6'h00);
		check_phy(2'h0);
		$display("t_defaults done");
	endtask : t_defaults

	// A second reset in mid-run with an attached, flipped, active-low state.
	task automatic t_mid_reset;
		do_reset({1'b0, 1'b1, 1'b1, 1'b1, 2'h0});
		$display("t_mid_reset done");
	endtask : t_mid_reset

	task automatic give_verdict;
		$display("fails %0d n_tests %0d", fails, n_tests);
		if (fails == 0 && n_tests > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask : give_verdict

	// Main sequence.
	initial begin
		do_reset(6'h08);
		t_defaults();
		t_scheme_one();
		t_scheme_two();
		t_mid_reset();
		give_verdict();
	end

	// The tests need well under a thousand cycles; this cuts a hang short.
	initial begin
		repeat (5000) @(posedge clk);
		fails++;
		$display("watchdog expired");
		give_verdict();
	end
endmodule : phy_select_tb_top

`default_nettype wire
